// File: hw/msqp_pkg.sv
// package for the mac status and queue pointer block
// assumes an ahb-lite slave with 32-bit data, one clock hclk
//
// Functional notes
// - network status bit 1 shows management data pin
// - bit 2 reads 1 when management idle
// - transmit flags clear on write one only
// - used bit read sets bit 0
// - collision during transmit sets bit 1
// - retry limit flag bit 2, write one clears
// - bit 3 high while transmit active
// - buffers exhausted: stop, bad fcs, tx_er, bit 4
// - frame complete sets bit 5
// - dma fetch failure sets underrun bit 6, bad crc
// - receive pointer advances, wraps at 1024 or wrap
// - transmit pointer advances, wraps at 1024 or wrap
// - transmit pointer writable only when not active
// - transmit pointer reads current frame first buffer
// - transmit disable stops, resets pointer to start
// - receive disable keeps receive pointer
package msqp_pkg;
  localparam logic [7:0] msqp_off_nsr = 8'h00;
  localparam logic [7:0] msqp_off_tsr = 8'h04;
  localparam logic [7:0] msqp_off_rqp = 8'h08;
  localparam logic [7:0] msqp_off_tqp = 8'h0c;
  localparam int msqp_nsr_mdio = 1;
  localparam int msqp_nsr_idle = 2;
  localparam int msqp_tsr_ubr = 0;
  localparam int msqp_tsr_col = 1;
  localparam int msqp_tsr_rle = 2;
  localparam int msqp_tsr_act = 3;
  localparam int msqp_tsr_bex = 4;
  localparam int msqp_tsr_comp = 5;
  localparam int msqp_tsr_und = 6;
  localparam logic [6:0] msqp_tsr_w1c_mask = 7'h77;
  localparam int msqp_ring_len = 1024;
  localparam int msqp_idx_w = 10;
  localparam logic [31:0] msqp_ptr_mask = 32'hffff_fffc;
  localparam logic [1:0] msqp_htrans_nonseq = 2'h2;
  localparam logic [1:0] msqp_htrans_seq = 2'h3;
endpackage

// File: hw/msqp_queue_ptr.sv
// one descriptor queue pointer: base, running index, wrap
// assumes advance pulses come from the dma, one per buffer used
`timescale 1ns/1ps
`default_nettype none
module msqp_queue_ptr #(
  parameter int ring_len = msqp_pkg::msqp_ring_len
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input wire logic [31:0] load_value,
  input wire logic rewind,
  input wire logic advance,
  input wire logic wrap_bit,
  output logic [31:0] ptr
);
  typedef struct packed {
    logic [31:0] base;
    logic [msqp_pkg::msqp_idx_w-1:0] idx;
  } msqp_qp_s;
  msqp_qp_s st, next_st;
  localparam logic [msqp_pkg::msqp_idx_w-1:0] last_idx =
    msqp_pkg::msqp_idx_w'(ring_len - 1);

  always_comb begin
    next_st = st;
    if (load) begin
      next_st.base = load_value & msqp_pkg::msqp_ptr_mask;
      next_st.idx = '0;
    end else if (rewind) begin
      next_st.idx = '0;
    end else if (advance) begin
      if (wrap_bit || st.idx == last_idx) begin
        next_st.idx = '0;
      end else begin
        next_st.idx = st.idx + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // each descriptor is two words, index scales by 8 bytes
  assign ptr = (st.base + {19'h0, st.idx, 3'h0}) & msqp_pkg::msqp_ptr_mask;
endmodule
`default_nettype wire

// File: hw/msqp_tx_flags.sv
// sticky transmit event flags, set wins over write-one clear
// assumes event inputs are single-cycle pulses from the tx engine
`timescale 1ns/1ps
`default_nettype none
module msqp_tx_flags (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [6:0] set_evt,
  input wire logic clr_we,
  input wire logic [6:0] clr_mask,
  output logic [6:0] flags
);
  typedef struct packed {
    logic [6:0] f;
  } msqp_tf_s;
  msqp_tf_s st, next_st;

  always_comb begin
    next_st = st;
    if (clr_we) begin
      next_st.f = st.f & ~(clr_mask & msqp_pkg::msqp_tsr_w1c_mask);
    end
    next_st.f = next_st.f | (set_evt & msqp_pkg::msqp_tsr_w1c_mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flags = st.f;
endmodule
`default_nettype wire

// File: hw/msqp_top.sv
// mac status and queue pointer registers behind an ahb-lite slave
// assumes tx engine, rx dma and management logic sit beside it on hclk
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module msqp_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic mdio_in,
  input wire logic mgmt_busy,
  input wire logic transmit_enable,
  input wire logic receive_enable,
  input wire logic tx_start,
  input wire logic tx_frame_done,
  input wire logic tx_used_bit_read,
  input wire logic tx_collision,
  input wire logic tx_retry_limit,
  input wire logic tx_buffers_out,
  input wire logic tx_dma_fail,
  input wire logic tx_buf_advance,
  input wire logic tx_buf_wrap,
  input wire logic rx_buf_advance,
  input wire logic rx_buf_wrap,
  output logic tx_er,
  output logic tx_bad_crc,
  output logic tx_abort,
  output logic rx_flush,
  output logic [31:0] rx_desc_ptr,
  output logic [31:0] tx_desc_ptr
);
  typedef struct packed {
    logic dph_valid;
    logic dph_write;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
    logic tx_active;
    logic tx_er;
    logic bad_crc;
    logic abort;
    logic rx_flush;
    logic te_q;
    logic [31:0] rx_ptr_q;
    logic [31:0] tx_ptr_q;
    logic [31:0] tx_frame_ptr;
  } msqp_top_s;
  msqp_top_s st, next_st;

  logic [31:0] rx_ptr;
  logic [31:0] tx_ptr;
  logic [6:0] flags;
  logic [6:0] set_evt;
  logic tsr_clr_we;
  logic rqp_load;
  logic tqp_load;
  logic tx_rewind;

  function automatic logic wr_hit(input msqp_top_s s, input logic [7:0] off);
    wr_hit = s.dph_valid && s.dph_write && s.dph_addr == off;
  endfunction

  // write data phase acts on the stored address
  assign tsr_clr_we = wr_hit(st, msqp_pkg::msqp_off_tsr);
  assign rqp_load = wr_hit(st, msqp_pkg::msqp_off_rqp);
  // writes while active are dropped silently
  assign tqp_load = wr_hit(st, msqp_pkg::msqp_off_tqp) && !st.tx_active;
  // falling transmit enable returns ring to its base
  assign tx_rewind = st.te_q && !transmit_enable;

  always_comb begin
    set_evt = '0;
    set_evt[msqp_pkg::msqp_tsr_ubr] = tx_used_bit_read;
    set_evt[msqp_pkg::msqp_tsr_col] = tx_collision && st.tx_active;
    set_evt[msqp_pkg::msqp_tsr_rle] = tx_retry_limit;
    set_evt[msqp_pkg::msqp_tsr_bex] = tx_buffers_out && st.tx_active;
    set_evt[msqp_pkg::msqp_tsr_comp] = tx_frame_done && st.tx_active;
    set_evt[msqp_pkg::msqp_tsr_und] = tx_dma_fail && st.tx_active;
  end

  msqp_tx_flags u_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .set_evt(set_evt),
    .clr_we(tsr_clr_we),
    .clr_mask(hwdata[6:0]),
    .flags(flags)
  );

  msqp_queue_ptr #(
    .ring_len(msqp_pkg::msqp_ring_len)
  ) u_rx_ptr (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(rqp_load),
    .load_value(hwdata),
    .rewind(1'b0),
    .advance(rx_buf_advance && receive_enable),
    .wrap_bit(rx_buf_wrap),
    .ptr(rx_ptr)
  );

  msqp_queue_ptr #(
    .ring_len(msqp_pkg::msqp_ring_len)
  ) u_tx_ptr (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(tqp_load),
    .load_value(hwdata),
    .rewind(tx_rewind),
    .advance(tx_buf_advance && st.tx_active),
    .wrap_bit(tx_buf_wrap),
    .ptr(tx_ptr)
  );

  always_comb begin
    logic ends;
    logic [31:0] rd;
    next_st = st;
    ends = tx_frame_done || tx_buffers_out || tx_dma_fail;
    next_st.te_q = transmit_enable;
    next_st.rx_ptr_q = rx_ptr;
    next_st.tx_ptr_q = tx_ptr;
    next_st.rx_flush = !receive_enable;
    next_st.tx_er = 1'b0;
    next_st.bad_crc = 1'b0;
    next_st.abort = 1'b0;
    if (!transmit_enable) begin
      next_st.tx_active = 1'b0;
      // one pulse on the falling enable, not a level while disabled
      next_st.abort = tx_rewind;
    end else if (st.tx_active && ends) begin
      next_st.tx_active = 1'b0;
      next_st.tx_er = tx_buffers_out;
      next_st.bad_crc = tx_buffers_out || tx_dma_fail;
    end else if (tx_start) begin
      next_st.tx_active = 1'b1;
    end
    // frame start pointer latched while idle
    if (!st.tx_active || tqp_load || tx_rewind) begin
      next_st.tx_frame_ptr = tx_ptr;
    end
    if (tx_frame_done && st.tx_active) begin
      next_st.tx_frame_ptr = tx_ptr;
    end
    rd = '0;
    case (haddr[7:0])
      msqp_pkg::msqp_off_nsr: begin
        rd[msqp_pkg::msqp_nsr_mdio] = mdio_in;
        rd[msqp_pkg::msqp_nsr_idle] = !mgmt_busy;
      end
      msqp_pkg::msqp_off_tsr: begin
        rd[6:0] = flags;
        rd[msqp_pkg::msqp_tsr_act] = st.tx_active;
      end
      msqp_pkg::msqp_off_rqp: rd = rx_ptr;
      // while idle the live pointer is the next frame's first buffer
      msqp_pkg::msqp_off_tqp: rd = st.tx_active ? st.tx_frame_ptr : tx_ptr;
      default: rd = '0;
    endcase
    if (hready) begin
      next_st.dph_valid = hsel && (htrans == msqp_pkg::msqp_htrans_nonseq ||
        htrans == msqp_pkg::msqp_htrans_seq);
      next_st.dph_write = hwrite;
      next_st.dph_addr = haddr[7:0] & msqp_pkg::msqp_ptr_mask[7:0];
      if (hsel && !hwrite) begin
        next_st.rdata = rd;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign tx_er = st.tx_er;
  assign tx_bad_crc = st.bad_crc;
  assign tx_abort = st.abort;
  assign rx_flush = st.rx_flush;
  assign rx_desc_ptr = st.rx_ptr_q;
  assign tx_desc_ptr = st.tx_ptr_q;
endmodule
`default_nettype wire

// File: verification/msqp_phy_model.sv
// phy side model: management port pin, busy flag and collision line
// assumes hclk domain; the bench requests each action by a pulse
`timescale 1ns/1ps
`default_nettype none
module msqp_phy_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mgmt_go,
  input wire logic col_go,
  input wire logic pin_lvl,
  output logic mdio_in,
  output logic mgmt_busy,
  output logic tx_collision
);
  logic [3:0] cnt;
  // pin toggles during a frame so a stale sample cannot pass
  assign mdio_in = mgmt_busy ? cnt[0] : pin_lvl;
  assign mgmt_busy = cnt != 4'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
      tx_collision <= 1'b0;
    end else begin
      cnt <= mgmt_go ? 4'h8 : cnt - {3'h0, mgmt_busy};
      tx_collision <= col_go;
    end
  end
endmodule
`default_nettype wire

// File: verification/msqp_top_monitor.sv
// assertions on msqp_top ports, bound below
// assumes one clock hclk and async active-low hresetn
`timescale 1ns/1ps
`default_nettype none
module msqp_top_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic receive_enable,
  input wire logic transmit_enable,
  input wire logic tx_buffers_out,
  input wire logic tx_dma_fail,
  input wire logic rx_flush,
  input wire logic tx_er,
  input wire logic tx_bad_crc,
  input wire logic tx_abort,
  input wire logic [31:0] rx_desc_ptr,
  input wire logic [31:0] tx_desc_ptr
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_exh;
    tx_buffers_out ##1 tx_er;
  endsequence
  property p_rx_al; rx_desc_ptr[1:0] == 2'h0; endproperty
  a_rx_al: assert property (p_rx_al) else $error("rx ptr unaligned");
  property p_tx_al; tx_desc_ptr[1:0] == 2'h0; endproperty
  a_tx_al: assert property (p_tx_al) else $error("tx ptr unaligned");
  // first edge after reset still sees the reset value
  property p_flush; $past(hresetn) |-> rx_flush == !$past(receive_enable); endproperty
  a_flush: assert property (p_flush) else $error("rx flush wrong");
  property p_er; tx_er |-> $past(tx_buffers_out); endproperty
  a_er: assert property (p_er) else $error("tx_er without cause");
  property p_er_once; s_exh |=> !tx_er; endproperty
  a_er_once: assert property (p_er_once) else $error("tx_er too long");
  property p_crc; tx_bad_crc |-> $past(tx_buffers_out) || $past(tx_dma_fail); endproperty
  a_crc: assert property (p_crc) else $error("bad crc without cause");
  property p_abort; tx_abort |-> !$past(transmit_enable); endproperty
  a_abort: assert property (p_abort) else $error("abort while enabled");
  property p_ab_once; tx_abort |=> !tx_abort; endproperty
  a_ab_once: assert property (p_ab_once) else $error("abort too long");
endmodule
bind msqp_top msqp_top_monitor u_msqp_top_monitor (.hclk(hclk), .hresetn(hresetn),
  .receive_enable(receive_enable), .transmit_enable(transmit_enable),
  .tx_buffers_out(tx_buffers_out), .tx_dma_fail(tx_dma_fail), .rx_flush(rx_flush),
  .tx_er(tx_er), .tx_bad_crc(tx_bad_crc), .tx_abort(tx_abort),
  .rx_desc_ptr(rx_desc_ptr), .tx_desc_ptr(tx_desc_ptr));
`default_nettype wire

// File: verification/tb_msqp_top.sv
// self-checking bench for msqp_top with a phy model
// assumes the phy model and the bound monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_msqp_top;
  logic ck = 0, rn = 0, s = 0, wr = 0, te = 0, re = 0, st = 0, mg = 0, pin = 1;
  logic md, bz, col, rdy;
  logic [31:0] a = 0, wd = 0, rd, r, b;
  logic [1:0] t = 0;
  logic [6:0] ev = 0;
  logic [3:0] q = 0;
  int error_cnt = 0, check_count = 0, i;
  always #12.5 ck = ~ck;
  msqp_phy_model u_msqp_phy_model (.hclk(ck), .hresetn(rn), .mgmt_go(mg), .col_go(ev[1]),
    .pin_lvl(pin), .mdio_in(md), .mgmt_busy(bz), .tx_collision(col));
  msqp_top u_msqp_top (.hclk(ck), .hresetn(rn), .hsel(s), .haddr(a), .htrans(t),
    .hwrite(wr), .hsize(3'h2), .hwdata(wd), .hready(rdy), .hrdata(rd), .hreadyout(rdy),
    .hresp(), .mdio_in(md), .mgmt_busy(bz), .transmit_enable(te), .receive_enable(re),
    .tx_start(st), .tx_frame_done(ev[5]), .tx_used_bit_read(ev[0]), .tx_collision(col),
    .tx_retry_limit(ev[2]), .tx_buffers_out(ev[4]), .tx_dma_fail(ev[6]),
    .tx_buf_advance(q[0]), .tx_buf_wrap(q[1]), .rx_buf_advance(q[2]), .rx_buf_wrap(q[3]),
    .tx_er(), .tx_bad_crc(), .tx_abort(), .rx_flush(), .rx_desc_ptr(), .tx_desc_ptr());
  function automatic logic [31:0] pexp(input logic [31:0] base, input int n);
    return (base & 32'hffff_fffc) + 32'(8 * (n % msqp_pkg::msqp_ring_len));
  endfunction
  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge ck);
  endtask
  task automatic err(input string m);
    error_cnt++;
    $display("Error %0t %s", $time, m);
  endtask
  task automatic wt;
    tk(1);
    for (int n = 0; rdy !== 1'b1; n++) begin
      if (n > 40) begin
        err("bus hang");
        end_sim;
      end
      tk(1);
    end
  endtask
  task automatic xf(input logic w, input logic [31:0] ad, d);
    s <= 1;
    t <= 2'h2;
    a <= ad;
    wr <= w;
    wt;
    s <= 0;
    t <= 2'h0;
    wd <= d;
    wt;
    r = rd;
  endtask
  task automatic cr(input logic [31:0] ad, e, m);
    xf(0, ad, 0);
    check_count++;
    if ((r & m) !== (e & m)) err($sformatf("addr %h got %h exp %h", ad, r, e));
  endtask
  task automatic pe(input logic [6:0] m);
    ev <= m;
    tk(1);
    ev <= 0;
    tk(2);
  endtask
  task automatic go;
    te <= 1;
    st <= 1;
    tk(1);
    st <= 0;
  endtask
  initial begin
    void'($urandom(32'hb5bebcfd));
    tk(2);
    rn <= 1;
    tk(1);
    xf(1, 32'h10, '1);
    cr(32'h10, 0, '1);
    xf(1, 32'h0, '1);
    for (i = 0; i < 6; i++) begin
      pin <= $urandom;
      tk(1);
      cr(32'h0, {29'h0, 1'b1, pin, 1'b0}, '1);
    end
    mg <= 1;
    tk(1);
    mg <= 0;
    cr(32'h0, 0, 4);
    tk(12);
    cr(32'h0, 4, 4);
    // each sticky flag: set, survives a zero write, clears on a one
    for (i = 0; i < 7; i++) begin
      if (i != 3) begin
        go;
        cr(32'h4, 8, '1);
        pe(7'h1 << i);
        cr(32'h4, 1 << i, ~8);
        xf(1, 32'h4, $urandom & ~(1 << i));
        cr(32'h4, 1 << i, ~8);
        xf(1, 32'h4, 1 << i);
        te <= 0;
        tk(2);
        cr(32'h4, 0, '1);
      end
    end
    b = $urandom & 32'hffff_fffb;
    xf(1, 32'hc, b);
    cr(32'hc, pexp(b, 0), '1);
    go;
    xf(1, 32'hc, ~b);
    q <= 4'h1;
    tk(3);
    q <= 0;
    cr(32'hc, pexp(b, 0), '1);
    pe(7'h20);
    cr(32'hc, pexp(b, 3), '1);
    b = $urandom & 32'hffff_fffb;
    xf(1, 32'hc, b);
    te <= 0;
    tk(2);
    cr(32'hc, pexp(b, 0), '1);
    b = $urandom & 32'hffff_fffb;
    re <= 1;
    xf(1, 32'h8, b);
    q <= 4'h4;
    tk(1024);
    q <= 0;
    cr(32'h8, pexp(b, 0), '1);
    q <= 4'h4;
    tk(3);
    q <= 4'hc;
    tk(1);
    q <= 4'h4;
    tk(2);
    q <= 0;
    cr(32'h8, pexp(b, 2), '1);
    re <= 0;
    q <= 4'h4;
    tk(2);
    q <= 0;
    cr(32'h8, pexp(b, 2), '1);
    tk(2);
    end_sim;
  end
endmodule
`default_nettype wire
